// ### rtk_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: shared constants for the rtc timekeeping and interval timer block
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   register indices are kept; byte address is four times the index
//////////////////////////////////////////////////////////////////////////////
package rtk_pkg;

  // register indices, byte address = index * 4
  localparam logic [7:0] IDX_CONFIG = 8'ha1;
  localparam logic [7:0] IDX_FRAC   = 8'ha2;
  localparam logic [7:0] IDX_SEC    = 8'ha3;
  localparam logic [7:0] IDX_MIN    = 8'ha4;
  localparam logic [7:0] IDX_HOUR   = 8'ha5;
  localparam logic [7:0] IDX_IVAL   = 8'ha6;
  localparam logic [7:0] IDX_KEY    = 8'ha7;
  localparam logic [7:0] IDX_IRQST  = 8'ha8;
  localparam logic [7:0] IDX_IRQMSK = 8'ha9;

  // apb address width
  localparam int unsigned PADDR_W = 12;

  // configuration register field positions
  localparam int unsigned CFG_RSVD0    = 0;
  localparam int unsigned CFG_INTERVAL_ENABLE     = 1;
  localparam int unsigned CFG_ALARM    = 2;
  localparam int unsigned CFG_SIT      = 3;
  localparam int unsigned CFG_ITS_LO   = 4;
  localparam int unsigned CFG_ITS_HI   = 5;
  localparam int unsigned CFG_TFH      = 6;
  localparam int unsigned CFG_MIDNIGHT = 7;
  localparam logic [7:0]  CFG_RESET    = 8'h01;

  // write-unlock key for the tallies
  localparam logic [7:0] UNLOCK_KEY = 8'hea;

  // tally wrap points
  localparam logic [7:0] FRAC_WRAP    = 8'h7f;
  localparam logic [7:0] SEC_WRAP     = 8'h3b;
  localparam logic [7:0] MIN_WRAP     = 8'h3b;
  localparam logic [7:0] HOUR_WRAP_24 = 8'h17;
  localparam logic [7:0] HOUR_WRAP_FF = 8'hff;
  localparam logic [7:0] TALLY_RESET  = 8'h00;

  // reference rate and tally rate, divider derived from both
  localparam int unsigned REF_HZ       = 32768;
  localparam int unsigned TALLY_HZ     = 128;
  localparam int unsigned REF_PER_TICK = REF_HZ / TALLY_HZ;
  localparam logic [7:0]  DIV_LAST     = 8'(REF_PER_TICK - 1);

  // interrupt status bit positions
  localparam int unsigned IRQ_ALARM    = 0;
  localparam int unsigned IRQ_MIDNIGHT = 1;
  localparam int unsigned IRQ_W        = 2;

  // interval time base select
  typedef enum logic [1:0] {
    ITS_FRAC = 2'b00,
    ITS_SEC  = 2'b01,
    ITS_MIN  = 2'b10,
    ITS_HOUR = 2'b11
  } rtk_its_t;

  // apb slave phase
  typedef enum logic [1:0] {
    APB_IDLE = 2'b00,
    APB_RESP = 2'b01
  } rtk_apb_t;

endpackage

// ### rtk_tick_gen.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: divides the calibrated reference pulse down to the 1/128 s tick
// Assumes: ref_tick is a one-cycle pulse at 32.768 kHz, synchronous to clk
// Notes:   divider state survives soft resets, only power-on clears it
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
module rtk_tick_gen (
  input  wire logic clk,      // pclk
  input  wire logic rst_n,    // power-on reset, active low
  input  wire logic ce,       // clock enable
  input  wire logic ref_tick, // calibrated reference pulse
  output logic      tick      // 1/128 s pulse
);

  logic [7:0] div_r;

  // count reference pulses, pulse on the last one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 8'h00;
      tick  <= 1'b0;
    end else if (ce) begin
      tick <= 1'b0;
      if (ref_tick) begin
        if (div_r == rtk_pkg::DIV_LAST) begin
          div_r <= 8'h00;
          tick  <= 1'b1;
        end else begin
          div_r <= 8'(div_r + 8'h01);
        end
      end
    end
  end

endmodule

// ### rtk_top.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: rtc timekeeping chain and interval alarm timer, apb slave
// Assumes: ref_tick_32k is the calibrated 32.768 kHz reference as a pulse
// Notes:   presetn is power-on reset; soft_rst is watchdog or external reset
//
// How it works
// - fractional tally advances every 1/128 s from the 32.768 kHz reference
// - fractional tally wraps 127 to 00 and bumps seconds
// - seconds wrap past 59 to 00 and bump minutes
// - minutes wrap past 59 to 00 and bump hours
// - tallies survive soft resets, clear only on power-on reset
// - repeat mode: alarm on interval count, then count restarts
// - single mode: alarm once after one interval
// - alarm flag lives in configuration bit 2
// - software clears the alarm; writing one does nothing
// - enable low disables the timer and holds its counter at zero
// - writing enable high starts counting on the chosen time base
// - 24-hour mode wraps hours 23 to 0, else 255 to 0
// - interval elapses when tick count equals the compare value
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
module rtk_top (
  input  wire logic        pclk,         // bus clock, 25 MHz
  input  wire logic        presetn,      // power-on reset, active low
  input  wire logic        pce,          // clock enable, freezes all state
  input  wire logic        soft_rst,     // watchdog or external reset
  input  wire logic        ref_tick_32k, // calibrated reference pulse
  input  wire logic [11:0] paddr,        // apb address
  input  wire logic        psel,         // apb select
  input  wire logic        penable,      // apb enable
  input  wire logic        pwrite,       // apb direction
  input  wire logic [31:0] pwdata,       // apb write data
  output logic      [31:0] prdata,       // apb read data
  output logic             pready,       // apb ready
  output logic             pslverr,      // apb error
  output logic             irq           // level interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  rtk_pkg::rtk_apb_t apb_r;
  rtk_pkg::rtk_apb_t apb_nxt;
  rtk_pkg::rtk_its_t its_r;

  logic        interval_enable_r;
  logic        alarm_r;
  logic        sit_r;
  logic        tfh_r;
  logic        midnight_r;
  logic        rsvd0_r;
  logic [7:0]  ival_r;
  logic [7:0]  key_r;
  logic [7:0]  icnt_r;
  logic        idone_r;
  logic [1:0]  irq_st_r;
  logic [1:0]  irq_msk_r;

  logic        tick_128;
  logic [7:0]  frac_val;
  logic [7:0]  sec_val;
  logic [7:0]  min_val;
  logic [7:0]  hour_val;
  logic        frac_carry;
  logic        sec_carry;
  logic        min_carry;
  logic        hour_carry;
  logic [7:0]  hour_wrap;

  logic        addr_ok;
  logic [7:0]  idx;
  logic        sel_cfg;
  logic        sel_frac;
  logic        sel_sec;
  logic        sel_min;
  logic        sel_hour;
  logic        sel_ival;
  logic        sel_key;
  logic        sel_ist;
  logic        sel_imsk;
  logic        sel_tally;
  logic        mapped;
  logic        key_ok;
  logic        wr_commit;
  logic        wr_bad;
  logic [7:0]  wbyte;
  logic [31:0] rd_data;

  logic        base_tick;
  logic [7:0]  icnt_inc;
  logic        alarm_set;
  logic [1:0]  irq_ev;

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  // word aligned and inside the index window
  assign addr_ok   = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
  assign idx       = paddr[9:2];
  assign sel_cfg   = addr_ok && (idx == rtk_pkg::IDX_CONFIG);
  assign sel_frac  = addr_ok && (idx == rtk_pkg::IDX_FRAC);
  assign sel_sec   = addr_ok && (idx == rtk_pkg::IDX_SEC);
  assign sel_min   = addr_ok && (idx == rtk_pkg::IDX_MIN);
  assign sel_hour  = addr_ok && (idx == rtk_pkg::IDX_HOUR);
  assign sel_ival  = addr_ok && (idx == rtk_pkg::IDX_IVAL);
  assign sel_key   = addr_ok && (idx == rtk_pkg::IDX_KEY);
  assign sel_ist   = addr_ok && (idx == rtk_pkg::IDX_IRQST);
  assign sel_imsk  = addr_ok && (idx == rtk_pkg::IDX_IRQMSK);
  assign sel_tally = sel_frac | sel_sec | sel_min | sel_hour;
  assign mapped    = sel_cfg | sel_tally | sel_ival | sel_key | sel_ist | sel_imsk;

  // tally writes need the unlock key
  assign key_ok    = (key_r == rtk_pkg::UNLOCK_KEY);

  // a write lands only on the edge that sees pready high
  assign wr_commit = psel & penable & pwrite & pready;
  assign wr_bad    = ~mapped | (sel_tally & ~key_ok);
  assign wbyte     = pwdata[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // apb handshake: one wait state, response from flops

  // next phase
  always_comb begin
    case (apb_r)
      rtk_pkg::APB_IDLE: apb_nxt = (psel & penable) ? rtk_pkg::APB_RESP : rtk_pkg::APB_IDLE;
      rtk_pkg::APB_RESP: apb_nxt = rtk_pkg::APB_IDLE;
      default:           apb_nxt = rtk_pkg::APB_IDLE;
    endcase
  end

  // read mux, unused bits read zero
  always_comb begin
    rd_data = 32'h0000_0000;
    if (sel_cfg) begin
      rd_data[7:0] = {midnight_r, tfh_r, its_r, sit_r, alarm_r, interval_enable_r, rsvd0_r};
    end else if (sel_frac) begin
      rd_data[7:0] = frac_val;
    end else if (sel_sec) begin
      rd_data[7:0] = sec_val;
    end else if (sel_min) begin
      rd_data[7:0] = min_val;
    end else if (sel_hour) begin
      rd_data[7:0] = hour_val;
    end else if (sel_ival) begin
      rd_data[7:0] = ival_r;
    end else if (sel_key) begin
      rd_data[7:0] = key_r;
    end else if (sel_ist) begin
      rd_data[1:0] = irq_st_r;
    end else if (sel_imsk) begin
      rd_data[1:0] = irq_msk_r;
    end
  end

  // phase, ready, read data and error flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_r   <= rtk_pkg::APB_IDLE;
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (pce) begin
      apb_r  <= apb_nxt;
      pready <= (apb_nxt == rtk_pkg::APB_RESP);
      if (apb_nxt == rtk_pkg::APB_RESP) begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_data;
        pslverr <= pwrite ? wr_bad : ~mapped;
      end else begin
        prdata  <= 32'h0000_0000;
        pslverr <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timekeeping chain

  // 1/128 s tick from the calibrated reference
  rtk_tick_gen u_tick (
    .clk      (pclk),
    .rst_n    (presetn),
    .ce       (pce),
    .ref_tick (ref_tick_32k),
    .tick     (tick_128)
  );

  // hour wrap point follows the day mode
  assign hour_wrap = tfh_r ? rtk_pkg::HOUR_WRAP_24 : rtk_pkg::HOUR_WRAP_FF;

  // fractional tally, 0..127
  rtk_wrap_cnt u_frac (
    .clk      (pclk),
    .rst_n    (presetn),
    .ce       (pce),
    .inc      (tick_128),
    .wrap_val (rtk_pkg::FRAC_WRAP),
    .ld       (wr_commit & sel_frac & key_ok),
    .ld_val   (wbyte),
    .val      (frac_val),
    .carry    (frac_carry)
  );

  // seconds, advanced by the fractional wrap
  rtk_wrap_cnt u_sec (
    .clk      (pclk),
    .rst_n    (presetn),
    .ce       (pce),
    .inc      (frac_carry),
    .wrap_val (rtk_pkg::SEC_WRAP),
    .ld       (wr_commit & sel_sec & key_ok),
    .ld_val   (wbyte),
    .val      (sec_val),
    .carry    (sec_carry)
  );

  // minutes, advanced by the seconds wrap
  rtk_wrap_cnt u_min (
    .clk      (pclk),
    .rst_n    (presetn),
    .ce       (pce),
    .inc      (sec_carry),
    .wrap_val (rtk_pkg::MIN_WRAP),
    .ld       (wr_commit & sel_min & key_ok),
    .ld_val   (wbyte),
    .val      (min_val),
    .carry    (min_carry)
  );

  // hours, advanced by the minutes wrap
  rtk_wrap_cnt u_hour (
    .clk      (pclk),
    .rst_n    (presetn),
    .ce       (pce),
    .inc      (min_carry),
    .wrap_val (hour_wrap),
    .ld       (wr_commit & sel_hour & key_ok),
    .ld_val   (wbyte),
    .val      (hour_val),
    .carry    (hour_carry)
  );

  ////////////////////////////////////////////////////////////////////////////
  // configuration register

  // day mode survives soft resets like the tallies
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tfh_r <= rtk_pkg::CFG_RESET[rtk_pkg::CFG_TFH];
    end else if (pce) begin
      if (wr_commit & sel_cfg) begin
        tfh_r <= wbyte[rtk_pkg::CFG_TFH];
      end
    end
  end

  // control fields, back to defaults on any reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      its_r   <= rtk_pkg::ITS_FRAC;
      sit_r   <= rtk_pkg::CFG_RESET[rtk_pkg::CFG_SIT];
      interval_enable_r  <= rtk_pkg::CFG_RESET[rtk_pkg::CFG_INTERVAL_ENABLE];
      rsvd0_r <= rtk_pkg::CFG_RESET[rtk_pkg::CFG_RSVD0];
    end else if (pce) begin
      if (soft_rst) begin
        its_r   <= rtk_pkg::ITS_FRAC;
        sit_r   <= rtk_pkg::CFG_RESET[rtk_pkg::CFG_SIT];
        interval_enable_r  <= rtk_pkg::CFG_RESET[rtk_pkg::CFG_INTERVAL_ENABLE];
        rsvd0_r <= rtk_pkg::CFG_RESET[rtk_pkg::CFG_RSVD0];
      end else if (wr_commit & sel_cfg) begin
        its_r   <= rtk_pkg::rtk_its_t'(wbyte[rtk_pkg::CFG_ITS_HI:rtk_pkg::CFG_ITS_LO]);
        sit_r   <= wbyte[rtk_pkg::CFG_SIT];
        interval_enable_r  <= wbyte[rtk_pkg::CFG_INTERVAL_ENABLE];
        rsvd0_r <= wbyte[rtk_pkg::CFG_RSVD0];
      end
    end
  end

  // alarm and midnight flags: hardware sets, writing zero clears, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_r    <= rtk_pkg::CFG_RESET[rtk_pkg::CFG_ALARM];
      midnight_r <= rtk_pkg::CFG_RESET[rtk_pkg::CFG_MIDNIGHT];
    end else if (pce) begin
      if (soft_rst) begin
        alarm_r    <= rtk_pkg::CFG_RESET[rtk_pkg::CFG_ALARM];
        midnight_r <= rtk_pkg::CFG_RESET[rtk_pkg::CFG_MIDNIGHT];
      end else begin
        alarm_r    <= alarm_set
                    | (alarm_r & ~(wr_commit & sel_cfg & ~wbyte[rtk_pkg::CFG_ALARM]));
        midnight_r <= hour_carry
                    | (midnight_r & ~(wr_commit & sel_cfg & ~wbyte[rtk_pkg::CFG_MIDNIGHT]));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare value and unlock key

  // interval compare and key, reset by any reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ival_r <= 8'h00;
      key_r  <= 8'h00;
    end else if (pce) begin
      if (soft_rst) begin
        ival_r <= 8'h00;
        key_r  <= 8'h00;
      end else begin
        if (wr_commit & sel_ival) begin
          ival_r <= wbyte;
        end
        if (wr_commit & sel_key) begin
          key_r <= wbyte;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interval timer

  // time base pick from the chain's own advance pulses
  always_comb begin
    case (its_r)
      rtk_pkg::ITS_FRAC: base_tick = tick_128;
      rtk_pkg::ITS_SEC:  base_tick = frac_carry;
      rtk_pkg::ITS_MIN:  base_tick = sec_carry;
      rtk_pkg::ITS_HOUR: base_tick = min_carry;
      default:           base_tick = 1'b0;
    endcase
  end

  // elapsed when the advanced count meets the compare value
  assign icnt_inc  = 8'(icnt_r + 8'h01);
  assign alarm_set = interval_enable_r & ~soft_rst & ~idone_r & base_tick
                   & (icnt_inc == ival_r);

  // interval counter, held at zero while disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      icnt_r  <= 8'h00;
      idone_r <= 1'b0;
    end else if (pce) begin
      if (soft_rst | ~interval_enable_r) begin
        icnt_r  <= 8'h00;
        idone_r <= 1'b0;
      end else if (base_tick & ~idone_r) begin
        if (alarm_set) begin
          icnt_r  <= sit_r ? icnt_inc : 8'h00;
          idone_r <= sit_r;
        end else begin
          icnt_r <= icnt_inc;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status, mask and output

  assign irq_ev = {hour_carry, alarm_set};

  // sticky status, write one to clear, event wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_r  <= 2'h0;
      irq_msk_r <= 2'h0;
    end else if (pce) begin
      if (soft_rst) begin
        irq_st_r  <= 2'h0;
        irq_msk_r <= 2'h0;
      end else begin
        irq_st_r <= irq_ev | (irq_st_r & ~((wr_commit & sel_ist) ? wbyte[1:0] : 2'h0));
        if (wr_commit & sel_imsk) begin
          irq_msk_r <= wbyte[1:0];
        end
      end
    end
  end

  // level interrupt from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else if (pce) begin
      irq <= |(irq_st_r & irq_msk_r);
    end
  end

endmodule

// ### rtk_top_chk.sv
// Purpose: port-level checks for the rtc timekeeping block
// Assumes: one clock domain, presetn is the power-on reset
// Notes:   bound to every rtk_top instance at the foot of this file
`timescale 1ns/100ps
module rtk_chk (
  input wire logic        pclk,         // bus clock
  input wire logic        presetn,      // power-on reset, active low
  input wire logic        pce,          // clock enable
  input wire logic        soft_rst,     // soft reset
  input wire logic [11:0] paddr,        // apb address
  input wire logic        psel,         // apb select
  input wire logic        penable,      // apb enable
  input wire logic        pwrite,       // apb direction
  input wire logic [31:0] pwdata,       // apb write data
  input wire logic [31:0] prdata,       // apb read data
  input wire logic        pready,       // apb ready
  input wire logic        pslverr,      // apb error
  input wire logic        irq           // interrupt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // address outside the map or not word aligned
  logic unmap;
  assign unmap = paddr < 12'h284 || paddr > 12'h2a4 || paddr[1:0] != 2'b00;

  //////////////////////////////////////////////////////////////////////////
  // named steps of an access and of a soft reset
  sequence s_take;
    pce && psel && penable && !pready;
  endsequence
  sequence s_mask_off;
    pready && pwrite && pce && paddr == 12'h2a4 && pwdata[1:0] == 2'b00 ##1 pce;
  endsequence
  sequence s_soft;
    soft_rst && pce ##1 pce;
  endsequence

  //////////////////////////////////////////////////////////////////////////
  AST_ACK: assert property (s_take |=> pready)
    else $error("access not answered in the next cycle");
  AST_ONE: assert property (pready && pce |=> !pready)
    else $error("ready held longer than one cycle");
  AST_UNMAP: assert property (s_take and unmap |=> pslverr)
    else $error("unmapped access without error");
  AST_UPPER: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  AST_WRZERO: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("read data driven on a write");
  AST_FREEZE: assert property (!pce |=> $stable(pready) && $stable(irq))
    else $error("outputs moved with clock enable low");
  AST_IRQ_MASK: assert property (s_mask_off |=> !irq)
    else $error("interrupt high with mask cleared");
  AST_SOFT: assert property (s_soft |=> !irq)
    else $error("interrupt survived soft reset");
endmodule

bind rtk_top rtk_chk u_chk (.pclk(pclk), .presetn(presetn), .pce(pce),
  .soft_rst(soft_rst), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq(irq));

// ### rtk_top_test.sv
// Purpose: self-checking bench for the rtc timekeeping block
// Assumes: reference pulse driven every cycle while time must pass
// Notes:   tallies are preloaded to reach wraps quickly
`timescale 1ns/100ps
module rtk_top_test;
  logic        pclk       = 1'b0;  // 25 MHz
  logic        presetn    = 1'b0;  // power-on reset
  logic        pce        = 1'b1;  // clock enable
  logic        soft_rst   = 1'b0;  // soft reset
  logic        ref_t      = 1'b0;  // reference pulse
  logic [11:0] paddr      = '0;    // address
  logic        psel       = 1'b0;  // select
  logic        penable    = 1'b0;  // enable
  logic        pwrite     = 1'b0;  // direction
  logic [31:0] pwdata     = '0;    // write data
  logic [31:0] prdata;             // read data
  logic        pready;             // ready
  logic        pslverr;            // error
  logic        irq;                // interrupt
  int          mismatches = 0;     // failed compares
  int          tests_run  = 0;     // compares made
  logic [7:0]  rd;                 // last read byte
  logic        er;                 // last error

  // clock
  always #20 pclk = ~pclk;

  rtk_top dut (.pclk(pclk), .presetn(presetn), .pce(pce), .soft_rst(soft_rst),
    .ref_tick_32k(ref_t), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));

  //////////////////////////////////////////////////////////////////////////
  // compares and bus tasks
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // hold the request until the edge that samples pready high
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // let registered side effects such as irq settle before returning
    @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    apb(1'b1, i, d);
  endtask
  task automatic rdc(input logic [7:0] i, input logic [7:0] e);
    apb(1'b0, i, 8'h00);
    chk8(rd, e);
  endtask
  // unlocked load of all tallies, key returned to zero
  task automatic ld(input logic [7:0] f, s, m, h);
    wr(rtk_pkg::IDX_KEY, rtk_pkg::UNLOCK_KEY);
    wr(rtk_pkg::IDX_FRAC, f);
    wr(rtk_pkg::IDX_SEC, s);
    wr(rtk_pkg::IDX_MIN, m);
    wr(rtk_pkg::IDX_HOUR, h);
    wr(rtk_pkg::IDX_KEY, 8'h00);
  endtask
  // k tally ticks of 256 reference pulses each
  task automatic ticks(input int k);
    @(posedge pclk);
    ref_t <= 1'b1;
    repeat (256 * k) @(posedge pclk);
    ref_t <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs;
    rdc(rtk_pkg::IDX_CONFIG, 8'h01);
    rdc(rtk_pkg::IDX_FRAC, 8'h00);
    rdc(rtk_pkg::IDX_SEC, 8'h00);
    rdc(rtk_pkg::IDX_MIN, 8'h00);
    apb(1'b0, 8'hb0, 8'h00);
    chk1(er, 1'b1);
    chk8(rd, 8'h00);
    apb(1'b1, rtk_pkg::IDX_SEC, 8'h05);
    chk1(er, 1'b1);
    rdc(rtk_pkg::IDX_SEC, 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_chain;
    ticks(3);
    rdc(rtk_pkg::IDX_FRAC, 8'h03);
    ld(8'h7f, 8'h3b, 8'h3b, 8'h00);
    ticks(1);
    rdc(rtk_pkg::IDX_FRAC, 8'h00);
    rdc(rtk_pkg::IDX_SEC, 8'h00);
    rdc(rtk_pkg::IDX_MIN, 8'h00);
    rdc(rtk_pkg::IDX_HOUR, 8'h01);
    wr(rtk_pkg::IDX_CONFIG, 8'h41);
    ld(8'h7f, 8'h3b, 8'h3b, 8'h17);
    ticks(1);
    rdc(rtk_pkg::IDX_HOUR, 8'h00);
    rdc(rtk_pkg::IDX_CONFIG, 8'hc1);
    wr(rtk_pkg::IDX_CONFIG, 8'h41);
    $display("t_chain done");
  endtask
  task automatic t_soft;
    ld(8'h22, 8'h05, 8'h07, 8'h03);
    @(posedge pclk);
    soft_rst <= 1'b1;
    @(posedge pclk);
    soft_rst <= 1'b0;
    rdc(rtk_pkg::IDX_FRAC, 8'h22);
    rdc(rtk_pkg::IDX_SEC, 8'h05);
    rdc(rtk_pkg::IDX_MIN, 8'h07);
    rdc(rtk_pkg::IDX_CONFIG, 8'h41);
    @(posedge pclk);
    pce <= 1'b0;
    repeat (3) @(posedge pclk);
    pce <= 1'b1;
    $display("t_soft done");
  endtask
  task automatic t_rep;
    wr(rtk_pkg::IDX_IRQMSK, 8'h01);
    wr(rtk_pkg::IDX_IVAL, 8'h02);
    wr(rtk_pkg::IDX_CONFIG, 8'h43);
    ticks(1);
    rdc(rtk_pkg::IDX_CONFIG, 8'h43);
    wr(rtk_pkg::IDX_CONFIG, 8'h41);
    wr(rtk_pkg::IDX_CONFIG, 8'h43);
    ticks(1);
    rdc(rtk_pkg::IDX_CONFIG, 8'h43);
    ticks(1);
    rdc(rtk_pkg::IDX_CONFIG, 8'h47);
    chk1(irq, 1'b1);
    wr(rtk_pkg::IDX_CONFIG, 8'h43);
    rdc(rtk_pkg::IDX_CONFIG, 8'h43);
    wr(rtk_pkg::IDX_CONFIG, 8'h47);
    rdc(rtk_pkg::IDX_CONFIG, 8'h43);
    ticks(2);
    rdc(rtk_pkg::IDX_CONFIG, 8'h47);
    wr(rtk_pkg::IDX_IRQMSK, 8'h00);
    chk1(irq, 1'b0);
    wr(rtk_pkg::IDX_IRQST, 8'h03);
    wr(rtk_pkg::IDX_IRQMSK, 8'h01);
    chk1(irq, 1'b0);
    wr(rtk_pkg::IDX_CONFIG, 8'h41);
    $display("t_rep done");
  endtask
  task automatic t_base;
    logic [7:0] c;
    wr(rtk_pkg::IDX_IVAL, 8'h01);
    for (int b = 0; b < 4; b++) begin
      c = 8'h4b | 8'(b << 4);
      ld(8'h7f, 8'h3b, 8'h3b, 8'h00);
      wr(rtk_pkg::IDX_CONFIG, c);
      ticks(1);
      rdc(rtk_pkg::IDX_CONFIG, c | 8'h04);
      wr(rtk_pkg::IDX_CONFIG, c);
      ticks(1);
      rdc(rtk_pkg::IDX_CONFIG, c);
      wr(rtk_pkg::IDX_CONFIG, 8'h41);
    end
    $display("t_base done");
  endtask

  //////////////////////////////////////////////////////////////////////////
  // verdict and run control
  task automatic conclude;
    $display("compares %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_chain();
    t_soft();
    t_rep();
    t_base();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    conclude();
  end
endmodule

// ### rtk_wrap_cnt.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: one 8-bit tally with load, increment and wrap
// Assumes: inc is a one-cycle pulse, ld has priority over inc for val, carry still follows inc
// Notes:   carry is combinational so a whole chain moves on one tick
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
module rtk_wrap_cnt (
  input  wire logic       clk,      // pclk
  input  wire logic       rst_n,    // power-on reset, active low
  input  wire logic       ce,       // clock enable
  input  wire logic       inc,      // advance pulse
  input  wire logic [7:0] wrap_val, // last value before wrap
  input  wire logic       ld,       // software load
  input  wire logic [7:0] ld_val,   // load data
  output logic      [7:0] val,      // current tally
  output logic            carry     // wraps on this inc
);

  // wrap detect feeds the next stage in the same cycle
  assign carry = inc & (val == wrap_val);

  // tally register, cleared only by power-on reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      val <= rtk_pkg::TALLY_RESET;
    end else if (ce) begin
      if (ld) begin
        val <= ld_val;
      end else if (inc) begin
        val <= (val == wrap_val) ? rtk_pkg::TALLY_RESET : 8'(val + 8'h01);
      end
    end
  end

endmodule
